// *** common/iebb_pkg.sv ***
// Constants and types shared by the interrupt enable/level bank
package iebb_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] TB0_CMP_IDX = 8'h99;
  localparam logic [7:0] TB1_CMP_IDX = 8'h9A;
  localparam logic [7:0] TB_OVF_IDX = 8'h9B;
  localparam logic [7:0] SER0_IDX = 8'h9C;
  localparam logic [7:0] SER1_IDX = 8'h9D;
  localparam logic [7:0] BUSIF_CLK_IDX = 8'h9E;
  localparam logic [7:0] DMA01_IDX = 8'hA0;
  localparam logic [7:0] DMA23_IDX = 8'hA1;

  localparam int NUM_REG = 8;
  localparam int NUM_SRC = 16;
  localparam logic [NUM_REG-1:0][7:0] REG_IDX = {
    DMA23_IDX, DMA01_IDX, BUSIF_CLK_IDX, SER1_IDX,
    SER0_IDX, TB_OVF_IDX, TB1_CMP_IDX, TB0_CMP_IDX
  };

  // ==========================================================
  // Field layout of each eight-bit register
  localparam int LVL_W = 3;
  localparam int HI_FLAG_BIT = 7;
  localparam int HI_LVL_LSB = 4;
  localparam int LO_FLAG_BIT = 3;
  localparam int LO_LVL_LSB = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [LVL_W-1:0] LVL_RESET = 3'h0;
  localparam logic [LVL_W-1:0] LVL_DISABLED = 3'h0;

  // ==========================================================
  // Bus decode
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    IEBB_BUS_IDLE = 4'h1,
    IEBB_BUS_WRITE = 4'h2,
    IEBB_BUS_RDWAIT = 4'h4,
    IEBB_BUS_RDDONE = 4'h8
  } iebb_bus_e;

endpackage : iebb_pkg

// *** design/iebb_flag_cell.sv ***
// Pending-request flag of one interrupt source
`timescale 1ns/1ps
module iebb_flag_cell (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Source event and processor acceptance
  input wire logic irq_event,
  input wire logic irq_accept,
  // Flag state
  output logic pending
);

  typedef struct packed {
    logic pending;
  } iebb_cell_s;

  iebb_cell_s state;
  iebb_cell_s next_state;

  // ==========================================================
  // Set on event, cleared on acceptance; set wins
  always_comb begin
    next_state = state;
    if (irq_event) begin
      next_state.pending = 1'b1;
    end else if (irq_accept) begin
      next_state.pending = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pending = state.pending;

endmodule : iebb_flag_cell

// *** design/iebb_bank.sv ***
// Interrupt enable/level register bank with AHB-Lite slave
`timescale 1ns/1ps
module iebb_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer B events
  input wire logic timer_b0_compare_a_irq,
  input wire logic timer_b0_compare_b_irq,
  input wire logic timer_b1_compare_a_irq,
  input wire logic timer_b1_compare_b_irq,
  input wire logic timer_b0_overflow_irq,
  input wire logic timer_b1_overflow_irq,
  // Serial, bus interface and clock calendar events
  input wire logic serial0_receive_irq,
  input wire logic serial0_transmit_irq,
  input wire logic serial1_receive_irq,
  input wire logic serial1_transmit_irq,
  input wire logic serial_bus_if_irq,
  input wire logic clock_calendar_irq,
  // Micro-DMA events
  input wire logic dma0_end_irq,
  input wire logic dma1_end_irq,
  input wire logic dma2_end_irq,
  input wire logic dma3_end_irq,
  // Processor acceptance side
  input wire logic [15:0] irq_accept,
  output logic [15:0] irq_request,
  output logic [47:0] irq_level
);

  typedef struct packed {
    iebb_pkg::iebb_bus_e bus;
    logic hit;
    logic [2:0] slot;
    logic [15:0][2:0] level;
    logic [15:0] request;
    logic [47:0] level_out;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
  } iebb_state_s;

  iebb_state_s state;
  iebb_state_s next_state;

  logic [15:0] src_event;
  logic [15:0] pending;
  logic addr_take;

  // ==========================================================
  // Source order: source 2k is the lower half of register k
  assign src_event = {
    dma3_end_irq, dma2_end_irq,
    dma1_end_irq, dma0_end_irq,
    clock_calendar_irq, serial_bus_if_irq,
    serial1_transmit_irq, serial1_receive_irq,
    serial0_transmit_irq, serial0_receive_irq,
    timer_b1_overflow_irq, timer_b0_overflow_irq,
    timer_b1_compare_b_irq, timer_b1_compare_a_irq,
    timer_b0_compare_b_irq, timer_b0_compare_a_irq
  };

  // ==========================================================
  // Pending flags, one cell per source
  generate
    for (genvar g = 0; g < iebb_pkg::NUM_SRC; g++) begin : g_src
      iebb_flag_cell u_flag (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .irq_event(src_event[g]),
        .irq_accept(irq_accept[g]),
        .pending(pending[g])
      );
    end
  endgenerate

  // ==========================================================
  // Address decode: index to register slot
  function automatic logic [3:0] decode_slot(input logic [7:0] idx);
    logic [3:0] res;
    res = 4'h0;
    for (int k = 0; k < iebb_pkg::NUM_REG; k++) begin
      if (idx == iebb_pkg::REG_IDX[k]) begin
        res = {1'b1, 3'(k)};
      end
    end
    return res;
  endfunction : decode_slot

  // Read image of one register
  function automatic logic [7:0] reg_image(
    input logic [2:0] slot,
    input logic [15:0] pend,
    input logic [15:0][2:0] lvl
  );
    logic [7:0] img;
    logic [3:0] lo;
    logic [3:0] hi;
    img = iebb_pkg::REG_RESET;
    lo = {slot, 1'b0};
    hi = {slot, 1'b1};
    img[iebb_pkg::HI_FLAG_BIT] = pend[hi];
    img[iebb_pkg::HI_LVL_LSB +: iebb_pkg::LVL_W] = lvl[hi];
    img[iebb_pkg::LO_FLAG_BIT] = pend[lo];
    img[iebb_pkg::LO_LVL_LSB +: iebb_pkg::LVL_W] = lvl[lo];
    return img;
  endfunction : reg_image

  assign addr_take = hsel && hready && (htrans == iebb_pkg::HTRANS_NONSEQ);

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [3:0] dec;
    logic [3:0] lo;
    logic [3:0] hi;
    dec = 4'h0;
    lo = 4'h0;
    hi = 4'h0;
    next_state = state;
    next_state.resp = iebb_pkg::HRESP_OKAY;

    unique case (state.bus)
      iebb_pkg::IEBB_BUS_IDLE: begin
        next_state.bus = iebb_pkg::IEBB_BUS_IDLE;
      end
      iebb_pkg::IEBB_BUS_WRITE: begin
        next_state.bus = iebb_pkg::IEBB_BUS_IDLE;
        if (state.hit) begin
          lo = {state.slot, 1'b0};
          hi = {state.slot, 1'b1};
          // Flag bits are dropped on write
          next_state.level[hi] = hwdata[iebb_pkg::HI_LVL_LSB +: iebb_pkg::LVL_W];
          next_state.level[lo] = hwdata[iebb_pkg::LO_LVL_LSB +: iebb_pkg::LVL_W];
        end
      end
      iebb_pkg::IEBB_BUS_RDWAIT: begin
        next_state.bus = iebb_pkg::IEBB_BUS_RDDONE;
        next_state.readyout = 1'b1;
        next_state.rdata = 32'h0000_0000;
        if (state.hit) begin
          next_state.rdata[7:0] = reg_image(state.slot, pending, state.level);
        end
      end
      iebb_pkg::IEBB_BUS_RDDONE: begin
        next_state.bus = iebb_pkg::IEBB_BUS_IDLE;
      end
    endcase

    // New address phase; reads get one wait state
    if (addr_take) begin
      dec = decode_slot(haddr[iebb_pkg::IDX_MSB:iebb_pkg::IDX_LSB]);
      next_state.hit = dec[3];
      next_state.slot = dec[2:0];
      if (hwrite) begin
        next_state.bus = iebb_pkg::IEBB_BUS_WRITE;
      end else begin
        next_state.bus = iebb_pkg::IEBB_BUS_RDWAIT;
        next_state.readyout = 1'b0;
      end
    end

    // Forward only enabled pending sources
    for (int i = 0; i < iebb_pkg::NUM_SRC; i++) begin
      next_state.request[i] = pending[i] &&
        (state.level[i] != iebb_pkg::LVL_DISABLED);
      next_state.level_out[i*iebb_pkg::LVL_W +: iebb_pkg::LVL_W] = state.level[i];
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.bus <= iebb_pkg::IEBB_BUS_IDLE;
      state.readyout <= 1'b1;
      state.resp <= iebb_pkg::HRESP_OKAY;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata = state.rdata;
  assign hreadyout = state.readyout;
  assign hresp = state.resp;
  assign irq_request = state.request;
  assign irq_level = state.level_out;

endmodule : iebb_bank

// *** verification/iebb_bank_props.sv ***
// Port assertions for the interrupt enable/level bank
`timescale 1ns/1ps
module iebb_bank_props (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Sources and processor side
  input wire logic dma0_end_irq,
  input wire logic [15:0] irq_accept,
  input wire logic [15:0] irq_request,
  input wire logic [47:0] irq_level
);
  logic [15:0] lvl_on;
  logic take;
  always_comb begin
    for (int i = 0; i < 16; i++) lvl_on[i] = |irq_level[3*i+:3];
  end
  assign take = hsel && hready && htrans == iebb_pkg::HTRANS_NONSEQ;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_rd; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr; take && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_okay; hresp == iebb_pkg::HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_one; !hreadyout |=> hreadyout; endproperty
  a_one: assert property (p_one) else $error("long wait");
  property p_rst; $rose(rstn) |-> irq_request == 16'h0 && irq_level == 48'h0; endproperty
  a_rst: assert property (p_rst) else $error("not cleared by reset");
  property p_dis; (irq_request & ~lvl_on) == 16'h0; endproperty
  a_dis: assert property (p_dis) else $error("disabled source forwarded");
  property p_set; dma0_end_irq ##2 lvl_on[12] |-> irq_request[12]; endproperty
  a_set: assert property (p_set) else $error("event not forwarded");
  property p_clr; irq_accept[12] && !dma0_end_irq ##1 !dma0_end_irq |=> !irq_request[12];
  endproperty
  a_clr: assert property (p_clr) else $error("accept did not clear");
endmodule : iebb_bank_props
bind iebb_bank iebb_bank_props i_iebb_bank_props (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .dma0_end_irq(dma0_end_irq), .irq_accept(irq_accept), .irq_request(irq_request),
  .irq_level(irq_level));

// *** verification/iebb_cpu_model.sv ***
// Processor acceptance model answering pending requests
`timescale 1ns/1ps
module iebb_cpu_model (
  // Clock
  input wire logic clk_sys,
  // Bench control
  input wire logic ack_on,
  input wire logic [3:0] ack_wait,
  // Request and acceptance
  input wire logic [15:0] irq_request,
  output logic [15:0] irq_accept
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] hold = 2'h0;
  // Hold covers the two edges where the request still shows after acceptance
  always @(posedge clk_sys) begin
    irq_accept <= 16'h0;
    if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (!ack_on || irq_request == 16'h0) begin
      cnt <= 4'h0;
    end else if (cnt < ack_wait) begin
      cnt <= cnt + 4'h1;
    end else begin
      irq_accept <= irq_request & (~irq_request + 16'h1);
      cnt <= 4'h0;
      hold <= 2'h2;
    end
  end
endmodule : iebb_cpu_model

// *** verification/test_irq_enable_level_bank_b.sv ***
// Self-checking bench for the interrupt enable/level bank
`timescale 1ns/1ps
module test_irq_enable_level_bank_b;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic ack_on = 1'h0;
  logic hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [3:0] ack_wait = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [15:0] ev = 16'h0, acc, req;
  logic [47:0] lvl;
  int num_errors = 0;
  int checked = 0;
  always #2 clk_sys = ~clk_sys;
  iebb_bank i_iebb_bank (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_b0_compare_a_irq(ev[0]), .timer_b0_compare_b_irq(ev[1]),
    .timer_b1_compare_a_irq(ev[2]), .timer_b1_compare_b_irq(ev[3]),
    .timer_b0_overflow_irq(ev[4]), .timer_b1_overflow_irq(ev[5]),
    .serial0_receive_irq(ev[6]), .serial0_transmit_irq(ev[7]),
    .serial1_receive_irq(ev[8]), .serial1_transmit_irq(ev[9]),
    .serial_bus_if_irq(ev[10]), .clock_calendar_irq(ev[11]), .dma0_end_irq(ev[12]),
    .dma1_end_irq(ev[13]), .dma2_end_irq(ev[14]), .dma3_end_irq(ev[15]),
    .irq_accept(acc), .irq_request(req), .irq_level(lvl));
  iebb_cpu_model i_iebb_cpu_model (.clk_sys(clk_sys), .ack_on(ack_on), .ack_wait(ack_wait),
    .irq_request(req), .irq_accept(acc));
  task automatic give_verdict;
    if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input logic on_bus);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      rd = hrdata;
      n++;
    end while ((on_bus ? hreadyout !== 1'h1 : req !== 16'h0) && n < 50);
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
    @(posedge clk_sys);
  endtask : wt
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= iebb_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wt(1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt(1'h1);
  endtask : bus
  task automatic pulse(input int i);
    ev[i] <= 1'h1;
    @(posedge clk_sys);
    ev[i] <= 1'h0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : pulse
  task automatic drain(input logic [3:0] w);
    ack_wait <= w;
    ack_on <= 1'h1;
    wt(1'h0);
    ack_on <= 1'h0;
  endtask : drain
  task automatic t_reset;
    for (int k = 0; k < 8; k++) begin
      bus(1'h0, iebb_pkg::REG_IDX[k], 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'h1, 8'h00, 32'hFFFFFFFF);
    bus(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
  endtask : t_reset
  task automatic t_levels;
    logic [2:0] hi, lo;
    for (int k = 0; k < 8; k++) begin
      hi = 3'(k % 7 + 1);
      lo = 3'(7 - k % 7);
      bus(1'h1, iebb_pkg::REG_IDX[k], {24'hFFFFFF, 1'h1, hi, 1'h1, lo});
      bus(1'h0, iebb_pkg::REG_IDX[k], 32'h0);
      chk(rd, {24'h0, 1'h0, hi, 1'h0, lo});
      chk(32'(lvl[6*k+:6]), {26'h0, hi, lo});
    end
  endtask : t_levels
  task automatic t_sources;
    for (int i = 0; i < 16; i++) begin
      pulse(i);
      chk(32'(req), 32'h1 << i);
      @(posedge clk_sys);
      bus(1'h0, iebb_pkg::REG_IDX[i/2], 32'h0);
      chk(rd & 32'h88, (i % 2) ? 32'h80 : 32'h08);
      drain(4'(i % 4));
      bus(1'h0, iebb_pkg::REG_IDX[i/2], 32'h0);
      chk(rd & 32'h88, 32'h0);
    end
  endtask : t_sources
  task automatic t_disable;
    bus(1'h1, iebb_pkg::DMA01_IDX, 32'h70);
    pulse(12);
    chk(32'(req), 32'h0);
    @(posedge clk_sys);
    bus(1'h0, iebb_pkg::DMA01_IDX, 32'h0);
    chk(rd, 32'h78);
    bus(1'h1, iebb_pkg::DMA01_IDX, 32'h72);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(req), 32'h1000);
    @(posedge clk_sys);
    drain(4'h3);
  endtask : t_disable
  task automatic t_midreset;
    pulse(15);
    chk(32'(req), 32'h8000);
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(req), 32'h0);
    chk(lvl[31:0], 32'h0);
    chk(32'(lvl[47:32]), 32'h0);
    @(posedge clk_sys);
    for (int k = 0; k < 8; k++) begin
      bus(1'h0, iebb_pkg::REG_IDX[k], 32'h0);
      chk(rd, 32'h0);
    end
  endtask : t_midreset
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'h1;
    @(posedge clk_sys);
    t_reset();
    t_levels();
    t_sources();
    t_disable();
    t_midreset();
    give_verdict();
  end
endmodule : test_irq_enable_level_bank_b
